// ---- core/sram_port_pkg.sv ----
// Shared constants, organisations and carriers for the burst-2 SRAM port.
// Assumes a single system clock samples every pin of the link.
package sram_port_pkg;

  // ****************************************
  // Organisations and widths
  // ****************************************
  typedef enum {ORG_X8, ORG_X9, ORG_X18, ORG_X36} org_e;

  localparam int DATA_MAX   = 36;
  localparam int MASK_MAX   = 4;
  localparam int WORD_MAX   = 23;
  localparam int NIBBLE_W   = 2;
  localparam int CNT_W      = 3;
  localparam int FIFO_WORDS = 16;

  // Launch-clock half cycles from address edge to first word
  localparam logic [2:0] LAT_HALF_PLL = 3'h3;
  localparam logic [2:0] LAT_HALF_BYP = 3'h2;

  function automatic int data_w(org_e org);
    case (org)
      ORG_X8:  return 8;
      ORG_X9:  return 9;
      ORG_X18: return 18;
      default: return 36;
    endcase
  endfunction : data_w

  function automatic int mask_w(org_e org);
    case (org)
      ORG_X8:  return 2;
      ORG_X9:  return 1;
      ORG_X18: return 2;
      default: return 4;
    endcase
  endfunction : mask_w

  // Log2 of the word count, same capacity in every organisation but x8
  function automatic int word_w(org_e org);
    case (org)
      ORG_X8, ORG_X9: return 23;
      ORG_X18:        return 22;
      default:        return 21;
    endcase
  endfunction : word_w

  function automatic logic is_wide(org_e org);
    return (org == ORG_X18) || (org == ORG_X36);
  endfunction : is_wide

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic                k;
    logic                k_n;
    logic                c;
    logic                c_n;
    logic                out_clk_used;
    logic                loop_bypass_select;
    logic                load_strobe_n;
    logic                read_not_write;
    logic [WORD_MAX-1:0] addr;
    logic [DATA_MAX-1:0] dq;
    logic [MASK_MAX-1:0] mask;
  } pin_s;

  typedef struct packed {
    logic [WORD_MAX-1:0] idx;
    logic [DATA_MAX-1:0] d0;
    logic [DATA_MAX-1:0] d1;
    logic [MASK_MAX-1:0] m0;
    logic [MASK_MAX-1:0] m1;
  } wr_burst_s;

endpackage : sram_port_pkg

// ---- core/burst_fifo.sv ----
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on clk.
`timescale 1ns/1ns
module burst_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  input  wire logic         clk,
  input  wire logic         rst_b,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0] store [DEPTH];
  logic [AW:0]  wr_ptr;
  logic [AW:0]  rd_ptr;

  // ****************************************
  // Flags
  // ****************************************
  assign out_valid = (wr_ptr != rd_ptr);
  assign in_ready  = !((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign out_data  = store[rd_ptr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (in_valid && in_ready) begin
      store[wr_ptr[AW-1:0]] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_ptr <= '0;
    end else if (in_valid && in_ready) begin
      wr_ptr <= wr_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_ptr <= '0;
    end else if (out_valid && out_ready) begin
      rd_ptr <= rd_ptr + 1'b1;
    end
  end

endmodule : burst_fifo

// ---- core/ddr_burst2_sram_port.sv ----
// Burst-2 double-rate SRAM port: pins sampled by clk, array, write buffer.
// Assumes all link pins are asynchronous to clk and much slower than it.
//
// Functional notes
// - The array holds one of four organisations: 8M x 8, or one of 8M x 9, 4M x 18 and 2M x 36 of equal capacity.
// - An address is taken only on every second rising edge of k, one address per two-word burst.
// - Write data is taken on a rising edge of k and on the following rising edge of k_n, one word each.
// - Read data is launched on the output clock pair when it is used, otherwise on the k pair.
// - In the narrow organisations each address names two sequential words moved back to back.
// - In the narrow organisations the burst counter always starts at zero.
// - In the wide organisations the burst counter starts at the address lsb and covers two words.
// - With loop_bypass_select high the first read word leaves 1.5 cycles after the address edge.
// - With loop_bypass_select low the first read word leaves 1 cycle after the address edge.
// - The returned strobe pair changes together with the read data on the shared data pins.
// - Array writes are self-timed from the buffered burst with no pulse from the controller.
`timescale 1ns/1ns
module ddr_burst2_sram_port #(
  parameter sram_port_pkg::org_e ORG = sram_port_pkg::ORG_X36,
  parameter int WORD_W     = sram_port_pkg::word_w(ORG),
  parameter int FIFO_DEPTH = sram_port_pkg::FIFO_WORDS
) (
  input  wire logic                             clk,
  input  wire logic                             rst_b,
  input  wire logic                             k,
  input  wire logic                             k_n,
  input  wire logic                             c,
  input  wire logic                             c_n,
  input  wire logic                             out_clk_used,
  input  wire logic                             loop_bypass_select,
  input  wire logic                             load_strobe_n,
  input  wire logic                             read_not_write,
  input  wire logic [sram_port_pkg::WORD_MAX-1:0] addr,
  input  wire logic [sram_port_pkg::DATA_MAX-1:0] dq_in,
  input  wire logic [sram_port_pkg::NIBBLE_W-1:0] nibble_write_mask,
  input  wire logic [sram_port_pkg::MASK_MAX-1:0] byte_write_mask,
  output logic [sram_port_pkg::DATA_MAX-1:0]      dq_out,
  output logic                                  dq_oe,
  output logic                                  returned_strobe,
  output logic                                  returned_strobe_n
);
  import sram_port_pkg::*;

  localparam int  DW   = data_w(ORG);
  localparam int  MW   = mask_w(ORG);
  localparam int  GRAN = DW / MW;
  localparam logic WIDE = is_wide(ORG);
  localparam int  BW   = $bits(wr_burst_s);

  typedef enum {W_IDLE, W_BEAT0, W_BEAT1} wr_state_e;

  // Pin levels while the link is idle, so no false edge follows reset
  localparam pin_s PIN_IDLE = '{k_n: 1'b1, c_n: 1'b1, load_strobe_n: 1'b1, default: '0};
  // Longest clk gap between the two words of a burst
  localparam int   WORD_GAP = 64;

  function automatic logic [WORD_MAX-1:0] other_word(logic [WORD_MAX-1:0] i);
    return {i[WORD_MAX-1:1], ~i[0]};
  endfunction : other_word

  function automatic logic [DATA_MAX-1:0] merge(logic [DATA_MAX-1:0] old, logic [DATA_MAX-1:0] nw,
                                                logic [MASK_MAX-1:0] m);
    logic [DATA_MAX-1:0] r;
    r = old;
    for (int b = 0; b < DW; b++) begin
      if (!m[b / GRAN]) begin
        r[b] = nw[b];
      end
    end
    return r;
  endfunction : merge

  // ****************************************
  // Pin synchroniser and edge finder
  // ****************************************
  pin_s raw, s1, s2;
  logic k_p, kn_p, c_p, cn_p;
  logic k_r, kn_r, true_e, comp_e, launch_e;

  always_comb begin
    raw                    = '0;
    raw.k                  = k;
    raw.k_n                = k_n;
    raw.c                  = c;
    raw.c_n                = c_n;
    raw.out_clk_used       = out_clk_used;
    raw.loop_bypass_select = loop_bypass_select;
    raw.load_strobe_n      = load_strobe_n;
    raw.read_not_write     = read_not_write;
    raw.addr               = addr;
    raw.dq                 = dq_in;
    raw.mask               = (ORG == ORG_X8) ? {{(MASK_MAX-NIBBLE_W){1'b1}}, nibble_write_mask} : byte_write_mask;
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s1 <= PIN_IDLE;
      s2 <= PIN_IDLE;
    end else begin
      s1 <= raw;
      s2 <= s1;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      {k_p, kn_p, c_p, cn_p} <= {PIN_IDLE.k, PIN_IDLE.k_n, PIN_IDLE.c, PIN_IDLE.c_n};
    end else begin
      {k_p, kn_p, c_p, cn_p} <= {s2.k, s2.k_n, s2.c, s2.c_n};
    end
  end

  assign k_r      = s2.k & ~k_p;
  assign kn_r     = s2.k_n & ~kn_p;
  assign true_e   = s2.out_clk_used ? (s2.c & ~c_p) : k_r;
  assign comp_e   = s2.out_clk_used ? (s2.c_n & ~cn_p) : kn_r;
  assign launch_e = true_e | comp_e;

  // ****************************************
  // Address edge and burst counter
  // ****************************************
  logic                blocked;
  logic                fifo_in_ready;
  logic                accept;
  logic [WORD_MAX-1:0] start_idx;

  assign accept = k_r & ~blocked & ~s2.load_strobe_n & (s2.read_not_write | fifo_in_ready);
  assign start_idx = WIDE ? s2.addr : {s2.addr[WORD_MAX-2:0], 1'b0};

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      blocked <= 1'b0;
    end else if (k_r) begin
      blocked <= accept;
    end
  end

  // ****************************************
  // Write beats into the burst buffer
  // ****************************************
  wr_state_e wr_state;
  wr_burst_s wr_hold;
  logic      fifo_push;

  assign fifo_push = (wr_state == W_BEAT1) && kn_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_state <= W_IDLE;
    end else begin
      unique case (wr_state)
        W_IDLE:  if (accept && !s2.read_not_write) wr_state <= W_BEAT0;
        W_BEAT0: if (k_r) wr_state <= W_BEAT1;
        W_BEAT1: if (kn_r) wr_state <= W_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_hold <= '0;
    end else begin
      if (accept && !s2.read_not_write) begin
        wr_hold.idx <= start_idx;
      end
      if (wr_state == W_BEAT0 && k_r) begin
        wr_hold.d0 <= s2.dq;
        wr_hold.m0 <= s2.mask;
      end
    end
  end

  wr_burst_s push_word, pop_word;
  logic      pop_valid, pop_ready;

  always_comb begin
    push_word    = wr_hold;
    push_word.d1 = s2.dq;
    push_word.m1 = s2.mask;
  end

  burst_fifo #(.W(BW), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk       (clk),
    .rst_b     (rst_b),
    .in_valid  (fifo_push),
    .in_ready  (fifo_in_ready),
    .in_data   (push_word),
    .out_valid (pop_valid),
    .out_ready (pop_ready),
    .out_data  (pop_word)
  );

  // ****************************************
  // Self-timed array writer
  // ****************************************
  logic [DATA_MAX-1:0] mem [2**WORD_W];
  logic                wr_second;
  logic [WORD_MAX-1:0] wr_idx;

  assign pop_ready = wr_second;
  assign wr_idx    = wr_second ? other_word(pop_word.idx) : pop_word.idx;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_second <= 1'b0;
    end else if (pop_valid) begin
      wr_second <= ~wr_second;
    end
  end

  always_ff @(posedge clk) begin
    if (pop_valid) begin
      mem[wr_idx[WORD_W-1:0]] <= merge(mem[wr_idx[WORD_W-1:0]],
                                       wr_second ? pop_word.d1 : pop_word.d0,
                                       wr_second ? pop_word.m1 : pop_word.m0);
    end
  end

  // ****************************************
  // Read slots and launch
  // ****************************************
  logic                rd_valid [2];
  logic [CNT_W-1:0]    rd_cnt   [2];
  logic [WORD_MAX-1:0] rd_idx   [2];
  logic                rd_ptr;
  logic [CNT_W-1:0]    lat;
  logic                emit, emit_first;
  logic [WORD_MAX-1:0] emit_idx;

  assign lat = s2.loop_bypass_select ? LAT_HALF_PLL : LAT_HALF_BYP;

  always_comb begin
    emit       = 1'b0;
    emit_first = 1'b0;
    emit_idx   = '0;
    for (int i = 0; i < 2; i++) begin
      if (launch_e && rd_valid[i] && (rd_cnt[i] + 1'b1 == lat)) begin
        emit       = 1'b1;
        emit_first = 1'b1;
        emit_idx   = rd_idx[i];
      end else if (launch_e && rd_valid[i] && (rd_cnt[i] == lat)) begin
        emit     = 1'b1;
        emit_idx = other_word(rd_idx[i]);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rd_ptr <= 1'b0;
      for (int i = 0; i < 2; i++) begin
        rd_valid[i] <= 1'b0;
        rd_cnt[i]   <= '0;
        rd_idx[i]   <= '0;
      end
    end else begin
      for (int i = 0; i < 2; i++) begin
        if (launch_e && rd_valid[i]) begin
          rd_cnt[i] <= rd_cnt[i] + 1'b1;
          if (rd_cnt[i] == lat) begin
            rd_valid[i] <= 1'b0;
          end
        end
      end
      if (accept && s2.read_not_write) begin
        rd_valid[rd_ptr] <= 1'b1;
        // Output pair trails k: its edge for the address edge is not counted
        rd_cnt[rd_ptr]   <= s2.out_clk_used ? '1 : '0;
        rd_idx[rd_ptr]   <= start_idx;
        rd_ptr           <= ~rd_ptr;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      dq_out <= '0;
      dq_oe  <= 1'b0;
    end else if (launch_e) begin
      dq_oe <= emit;
      if (emit) begin
        dq_out <= mem[emit_idx[WORD_W-1:0]];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      returned_strobe   <= 1'b0;
      returned_strobe_n <= 1'b1;
    end else if (launch_e) begin
      returned_strobe   <= true_e;
      returned_strobe_n <= ~true_e;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence word_one_s;
    emit && emit_first;
  endsequence
  sequence word_two_s;
    emit && !emit_first;
  endsequence

  addr_edge_a: assert property (accept |=> !accept [*8]) else $error("address taken twice");
  burst_start_a: assert property (accept |-> (WIDE ? start_idx[0] == s2.addr[0] : !start_idx[0]))
    else $error("burst counter start wrong");
  write_beat_a: assert property (fifo_push |-> kn_r && fifo_in_ready) else $error("beat off k_n edge");
  launch_clock_a: assert property (emit |-> (s2.out_clk_used ? (s2.c & ~c_p) | (s2.c_n & ~cn_p) : k_r | kn_r))
    else $error("launch on wrong clock pair");
  two_words_a: assert property (word_one_s |=> !(emit && emit_first) throughout (##[0:WORD_GAP] word_two_s))
    else $error("burst split");
  latency_a: assert property (word_one_s |-> (s2.loop_bypass_select ? comp_e : true_e))
    else $error("first word on wrong phase");
  strobe_align_a: assert property (dq_oe && $changed(dq_out) |-> $changed(returned_strobe))
    else $error("data moved without strobe");
  self_timed_a: assert property (pop_valid && !wr_second |=> pop_valid && wr_second ##1 !wr_second)
    else $error("writer stalled");

endmodule : ddr_burst2_sram_port

// ---- sim/link_driver.sv ----
// Link-side controller model: drives the port pins, captures returned words.
// Assumes clk is the port clock; all pins change at its falling edge.
`timescale 1ns/1ns
module link_driver (
  input  wire logic                               clk,
  input  wire logic [sram_port_pkg::DATA_MAX-1:0] dq_out,
  input  wire logic                               dq_oe,
  input  wire logic                               returned_strobe,
  input  wire logic                               returned_strobe_n,
  output sram_port_pkg::pin_s                     pins
);
  import sram_port_pkg::*;
  // ****************
  // Capture
  // ****************
  logic [DATA_MAX-1:0] q_d [$];
  logic [1:0]          q_s [$];
  int                  q_t [$];
  int                  cyc = 0;
  int                  t_a = 0;
  logic                last = 1'b0;

  always @(posedge clk) cyc <= cyc + 1;

  always @(negedge clk) begin
    if (dq_oe === 1'b1 && returned_strobe !== last) begin
      q_d.push_back(dq_out);
      q_s.push_back({returned_strobe, returned_strobe_n});
      if (q_d.size() % 2 == 1) q_t.push_back(cyc - t_a);
    end
    last = returned_strobe;
  end

  // ****************
  // Drive
  // ****************
  initial begin
    pins = '0;
    pins.k_n = 1'b1;
    pins.c_n = 1'b1;
    pins.load_strobe_n = 1'b1;
  end

  task automatic setup(input logic byp, input logic ocu);
    @(negedge clk);
    pins.loop_bypass_select = byp;
    pins.out_clk_used = ocu;
  endtask : setup

  // One half period of k; output clocks trail k by four cycles
  task automatic half(input logic kv, ld, rw, input logic [WORD_MAX-1:0] a,
                      input logic [DATA_MAX-1:0] d, input logic [MASK_MAX-1:0] m);
    @(negedge clk);
    pins.c = pins.k;
    pins.c_n = ~pins.k;
    pins.load_strobe_n = ld;
    pins.read_not_write = rw;
    pins.addr = a;
    pins.dq = d;
    pins.mask = m;
    repeat (4) @(negedge clk);
    pins.k = kv;
    pins.k_n = ~kv;
    if (kv && !ld && rw) t_a = cyc;
    repeat (3) @(negedge clk);
  endtask : half

  // Idle data pins carry the inverse of their last value; address and direction carry the inverse of the burst's
  task automatic burst(input logic rw, ld1, input logic [WORD_MAX-1:0] a,
                       input logic [DATA_MAX-1:0] d0, d1, input logic [MASK_MAX-1:0] m0, m1);
    half(1'b1, 1'b0, rw, a, ~pins.dq, ~pins.mask);
    half(1'b0, 1'b1, ~rw, ~a, ~pins.dq, ~pins.mask);
    half(1'b1, ld1, ~rw, ~a, rw ? ~pins.dq : d0, m0);
    half(1'b0, 1'b1, ~rw, ~a, rw ? ~pins.dq : d1, m1);
  endtask : burst

  task automatic idle(input int n);
    repeat (n) begin
      half(1'b1, 1'b1, 1'b0, ~pins.addr, ~pins.dq, ~pins.mask);
      half(1'b0, 1'b1, 1'b0, ~pins.addr, ~pins.dq, ~pins.mask);
    end
  endtask : idle
endmodule : link_driver

// ---- sim/tb_ddr_burst2_sram_port.sv ----
// Self-checking bench for the burst-2 SRAM port, 36-bit organisation.
// Assumes link_driver as the controller and a 64-word array.
`timescale 1ns/1ns
module tb_ddr_burst2_sram_port;
  import sram_port_pkg::*;
  localparam int WW = 6;
  logic                clk = 1'b0;
  logic                rst_b = 1'b0;
  pin_s                pins;
  logic [DATA_MAX-1:0] dq_out;
  logic                dq_oe;
  logic                rs;
  logic                rs_n;
  int                  num_errors = 0;
  int                  num_checks = 0;
  integer              seed = 32'h7169;
  logic [DATA_MAX-1:0] mem [int];
  logic [DATA_MAX-1:0] exp_q [$];

  ddr_burst2_sram_port #(.ORG(ORG_X36), .WORD_W(WW), .FIFO_DEPTH(FIFO_WORDS)) uut (
    .clk(clk), .rst_b(rst_b), .k(pins.k), .k_n(pins.k_n), .c(pins.c), .c_n(pins.c_n),
    .out_clk_used(pins.out_clk_used), .loop_bypass_select(pins.loop_bypass_select),
    .load_strobe_n(pins.load_strobe_n), .read_not_write(pins.read_not_write),
    .addr(pins.addr), .dq_in(dq_oe ? dq_out : pins.dq), .nibble_write_mask(pins.mask[1:0]),
    .byte_write_mask(pins.mask), .dq_out(dq_out), .dq_oe(dq_oe),
    .returned_strobe(rs), .returned_strobe_n(rs_n)
  );

  link_driver drv (
    .clk(clk), .dq_out(dq_out), .dq_oe(dq_oe), .returned_strobe(rs),
    .returned_strobe_n(rs_n), .pins(pins)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // ****************
  // Model and checks
  // ****************
  task automatic check(input string what, input logic [DATA_MAX-1:0] e, g);
    num_checks++;
    if (e !== g) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask : check

  function automatic void put(input int i, input logic [DATA_MAX-1:0] d, input logic [MASK_MAX-1:0] m);
    if (!mem.exists(i)) mem[i] = '0;
    for (int b = 0; b < MASK_MAX; b++) begin
      if (!m[b]) mem[i][9*b +: 9] = d[9*b +: 9];
    end
  endfunction : put

  task automatic wr(input logic [WORD_MAX-1:0] a, input logic [MASK_MAX-1:0] m0, m1);
    logic [DATA_MAX-1:0] d0;
    logic [DATA_MAX-1:0] d1;
    d0 = DATA_MAX'({$random(seed), $random(seed)});
    d1 = DATA_MAX'({$random(seed), $random(seed)});
    drv.burst(1'b0, 1'b1, a, d0, d1, m0, m1);
    put(int'(a[WW-1:0]), d0, m0);
    put(int'(a[WW-1:0]) ^ 1, d1, m1);
  endtask : wr

  task automatic rd(input logic [WORD_MAX-1:0] a, input logic ld1);
    exp_q.push_back(mem[int'(a[WW-1:0])]);
    exp_q.push_back(mem[int'(a[WW-1:0]) ^ 1]);
    drv.burst(1'b1, ld1, a, '0, '0, '0, '0);
  endtask : rd

  task automatic drain(input string name, input int lo);
    int n;
    int t;
    drv.idle(3);
    n = exp_q.size();
    check("dq_oe after burst", '0, DATA_MAX'(dq_oe));
    check("word count", DATA_MAX'(n), DATA_MAX'(drv.q_d.size()));
    check("first word count", DATA_MAX'(n / 2), DATA_MAX'(drv.q_t.size()));
    for (int j = 0; j < n && drv.q_d.size() > 0; j++) begin
      check("read word", exp_q[j], drv.q_d.pop_front());
      check("strobe pair", (j[0] ^ pins.loop_bypass_select) ? 2'b01 : 2'b10, DATA_MAX'(drv.q_s.pop_front()));
    end
    while (drv.q_t.size() > 0) begin
      t = drv.q_t.pop_front();
      check("read latency", DATA_MAX'(lo), DATA_MAX'((t >= lo && t <= lo + 3) ? lo : t));
    end
    exp_q.delete();
    drv.q_d.delete();
    drv.q_s.delete();
    $display("test %s done", name);
  endtask : drain

  // ****************
  // Sequence
  // ****************
  initial begin
    repeat (12) @(negedge clk);
    check("reset flags", DATA_MAX'(3'b001), DATA_MAX'({dq_oe, rs, rs_n}));
    check("reset data", '0, dq_out);
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    for (int a = 0; a < 64; a += 2) wr(WORD_MAX'(a), '0, '0);
    drain("fill", 0);
    for (int c = 0; c < 4; c++) begin
      drv.setup(c[0], c[1]);
      repeat (6) rd(WORD_MAX'($random(seed)), 1'b1);
      drain("read modes", (c[0] ? 24 : 16) + (c[1] ? 4 : 0) + 2);
    end
    drv.setup(1'b0, 1'b0);
    repeat (8) wr(WORD_MAX'($random(seed)), MASK_MAX'($random(seed)), MASK_MAX'($random(seed)));
    for (int a = 0; a < 64; a += 2) rd(WORD_MAX'(a), 1'b1);
    drain("masked write", 18);
    rd(WORD_MAX'(5), 1'b0);
    rd(WORD_MAX'(58), 1'b1);
    drain("blocked edge", 18);
    finish_test();
  end

  initial begin
    #500_000;
    num_errors++;
    $display("CHECK FAILED watchdog expected done seen hang");
    finish_test();
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : finish_test
endmodule : tb_ddr_burst2_sram_port
